// *** src/mode_reg_pkg.sv ***
// Purpose: constants for the working-mode register decoder
// Assumes: 16-bit data, 5-bit reconfiguration port address
// Notes:   field positions and codes of the working-mode word
package mode_reg_pkg;

  localparam int          DATA_W          = 16;
  localparam int          ADDR_W          = 5;
  localparam logic [4:0]  MODE_REG_ADDR   = 5'h01;
  localparam logic [15:0] MODE_REG_RESET  = 16'h0000;
  localparam logic [15:0] RESERVED_MASK   = 16'h0700;

  localparam int SEQ_HI_POS     = 15;
  localparam int SEQ_LO_POS     = 14;
  localparam int TRIGGER_POS    = 13;
  localparam int HIGH_RATE_POS  = 12;
  localparam int CLK_SRC_POS    = 11;
  localparam int SUPPLY_HI_POS  = 7;
  localparam int SUPPLY_LO_POS  = 6;
  localparam int CHAN_HI_POS    = 5;
  localparam int CHAN_LO_POS    = 2;
  localparam int POLARITY_POS   = 1;
  localparam int DIFF_POS       = 0;

  localparam int NUM_INPUTS     = 12;
  localparam int NUM_PAIRS      = 6;

  // conversion rate limits in kilo-samples per second
  localparam int RATE_SEQ_KSPS  = 500;
  localparam int RATE_HIGH_KSPS = 1000;

  typedef enum logic [3:0] {
    MODE_DEFAULT     = 4'b0001,
    MODE_SINGLE_PASS = 4'b0010,
    MODE_CONTINUOUS  = 4'b0100,
    MODE_SINGLE_CHAN = 4'b1000
  } seq_mode_e;

  typedef enum logic [2:0] {
    SUPPLY_3V3 = 3'b001,
    SUPPLY_1V1 = 3'b010,
    SUPPLY_MEM = 3'b100
  } supply_sel_e;

  typedef enum logic [2:0] {
    PAIR_SINGLE   = 3'b001,
    PAIR_UNIPOLAR = 3'b010,
    PAIR_BIPOLAR  = 3'b100
  } pairing_e;

endpackage

// *** src/mode_seq_decode.sv ***
// Purpose: decode sequencing, rate, trigger and clock-source fields
// Assumes: word is the stored working-mode value
// Notes:   purely combinational
`timescale 1ns/10ps
module mode_seq_decode (
  input  wire logic [15:0]             word,
  output mode_reg_pkg::seq_mode_e      seq_mode,
  output logic                         event_driven,
  output logic                         high_rate,
  output logic                         clk_from_port,
  output logic                         single_or_high,
  output logic [10:0]                  max_rate_ksps
);
  import mode_reg_pkg::*;

  always_comb begin
    case ({word[SEQ_HI_POS], word[SEQ_LO_POS]})  // see [RULE_03]
      2'h0:    seq_mode = MODE_DEFAULT;
      2'h1:    seq_mode = MODE_SINGLE_PASS;
      2'h2:    seq_mode = MODE_CONTINUOUS;
      default: seq_mode = MODE_SINGLE_CHAN;
    endcase
    event_driven   = word[TRIGGER_POS];                        // see [RULE_05]
    high_rate      = word[HIGH_RATE_POS];                      // see [RULE_06]
    clk_from_port  = word[CLK_SRC_POS];                        // see [RULE_07]
    single_or_high = high_rate | (seq_mode == MODE_SINGLE_CHAN);
    max_rate_ksps  = high_rate ? 11'(RATE_HIGH_KSPS) : 11'(RATE_SEQ_KSPS);  // see [RULE_04]
  end

endmodule

// *** src/mode_chan_decode.sv ***
// Purpose: decode supply monitor, channel index and pairing fields
// Assumes: word is the stored working-mode value
// Notes:   input selections are valid only when enable is high; supply and pairing always decode
`timescale 1ns/10ps
module mode_chan_decode #(
  parameter int NUM_IN = 12
) (
  input  wire logic [15:0]             word,
  input  wire logic                    enable,
  output mode_reg_pkg::supply_sel_e    supply_sel,
  output mode_reg_pkg::pairing_e       pairing,
  output logic [NUM_IN-1:0]            input_sel,
  output logic [NUM_IN-1:0]            input_neg,
  output logic                         chan_valid
);
  import mode_reg_pkg::*;

  // the pair grouping and the 4-bit index only cover the documented input count
  if (NUM_IN != NUM_INPUTS) begin : g_bad_count
    $error("input count must be %0d", NUM_INPUTS);
  end

  logic [3:0] idx;
  logic       diff;

  always_comb begin
    idx  = word[CHAN_HI_POS:CHAN_LO_POS];
    diff = word[DIFF_POS];
    if (!word[SUPPLY_HI_POS]) begin  // see [RULE_08]
      supply_sel = SUPPLY_3V3;
    end else if (!word[SUPPLY_LO_POS]) begin
      supply_sel = SUPPLY_1V1;
    end else begin
      supply_sel = SUPPLY_MEM;
    end
    if (!diff) begin  // see [RULE_10]
      pairing = PAIR_SINGLE;
    end else if (word[POLARITY_POS]) begin
      pairing = PAIR_BIPOLAR;
    end else begin
      pairing = PAIR_UNIPOLAR;
    end
    chan_valid = enable && (idx < 4'(NUM_IN));  // see [RULE_09] [RULE_13]
  end

  // one selector per analog input
  for (genvar i = 0; i < NUM_IN; i++) begin : g_in
    always_comb begin
      if (!chan_valid) begin
        input_sel[i] = 1'b0;
        input_neg[i] = 1'b0;
      end else if (!diff) begin
        input_sel[i] = (idx == 4'(i));  // see [RULE_11]
        input_neg[i] = 1'b0;
      end else begin
        input_sel[i] = (idx[3:1] == 3'(i / 2));  // see [RULE_12]
        // even member is the negative side in unipolar pairs
        input_neg[i] = !word[POLARITY_POS] && (idx[3:1] == 3'(i / 2)) && (i % 2 == 0);  // see [RULE_14]
      end
    end
  end

endmodule

// *** src/mode_reg_top.sv ***
// Purpose: working-mode register with reconfiguration port access and decode
// Assumes: port signals synchronous to core_clk; one access per enable pulse
// Notes:   reads answer one cycle after the enable with ready
//
// Notes on behaviour
// [RULE_01] mode register lives at address 01h and is writable any time
// [RULE_02] writers must put zeros in reserved bits 10 to 8
// [RULE_03] bits 15:14 pick default, single-pass, continuous or single-channel
// [RULE_04] every sequence setting runs at most 0.5 MSPS while bit 12 is low
// [RULE_05] bit 13 low is continuous sampling, high is event-driven
// [RULE_06] bit 12 high forces 1 MSPS, low follows sequence field
// [RULE_07] bit 11 picks internal oscillator or port clock as converter clock
// [RULE_08] bits 7:6 route 3.3 V, core 1.1 V or memory supply to channel 13
// [RULE_09] channel index bits 5:2 used only in single-channel or 1 MSPS mode
// [RULE_10] pairing bits choose single-ended, unipolar or bipolar pairs
// [RULE_11] single-ended index 0 to 11 selects that input
// [RULE_12] paired modes: index 2k and 2k+1 select pair k
// [RULE_13] index 12 to 15 selects nothing whatever the pairing
// [RULE_14] unipolar pair: even input negative, odd input positive
// [RULE_15] controller should pulse converter reset after changing registers
// [RULE_16] a read returns the last written word, reserved bits included
`timescale 1ns/10ps
module mode_reg_top #(
  parameter int NUM_IN = 12
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        port_en,
  input  wire logic                        port_we,
  input  wire logic [4:0]                  port_addr,
  input  wire logic [15:0]                 port_wdata,
  output logic [15:0]                      port_rdata,
  output logic                             port_ready,
  output logic                             mode_written,
  output mode_reg_pkg::seq_mode_e          seq_mode,
  output logic                             event_driven,
  output logic                             high_rate,
  output logic                             clk_from_port,
  output logic [10:0]                      max_rate_ksps,
  output mode_reg_pkg::supply_sel_e        supply_sel,
  output mode_reg_pkg::pairing_e           pairing,
  output logic [NUM_IN-1:0]                input_sel,
  output logic [NUM_IN-1:0]                input_neg,
  output logic                             chan_valid,
  output logic                             reserved_nonzero
);
  import mode_reg_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] rdata;
    logic        ready;
    logic        written;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic   hit;
  logic   single_or_high;

  // ==========================================================
  // port access
  always_comb begin
    state_next         = state_reg;
    state_next.ready   = 1'b0;
    state_next.written = 1'b0;
    hit                = (port_addr == MODE_REG_ADDR);
    if (port_en) begin
      state_next.ready = 1'b1;
      if (port_we && hit) begin
        state_next.mode    = port_wdata;  // see [RULE_01]
        state_next.written = 1'b1;
      end
      // unmapped reads return zero so stale data never leaks
      state_next.rdata = (!port_we && hit) ? state_reg.mode : 16'h0000;  // see [RULE_16]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= '{mode: MODE_REG_RESET, rdata: 16'h0000, ready: 1'b0, written: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign port_rdata   = state_reg.rdata;
  assign port_ready   = state_reg.ready;
  // pulse lets the controller apply the advised converter reset
  assign mode_written = state_reg.written;  // see [RULE_15]
  // flags a writer that broke the zero convention; value is still kept
  assign reserved_nonzero = |(state_reg.mode & RESERVED_MASK);  // see [RULE_02]

  // ==========================================================
  // decode
  mode_seq_decode u_seq (
    .word           (state_reg.mode),
    .seq_mode       (seq_mode),
    .event_driven   (event_driven),
    .high_rate      (high_rate),
    .clk_from_port  (clk_from_port),
    .single_or_high (single_or_high),
    .max_rate_ksps  (max_rate_ksps)
  );

  mode_chan_decode #(.NUM_IN(NUM_IN)) u_chan (
    .word       (state_reg.mode),
    .enable     (single_or_high),  // see [RULE_09]
    .supply_sel (supply_sel),
    .pairing    (pairing),
    .input_sel  (input_sel),
    .input_neg  (input_neg),
    .chan_valid (chan_valid)
  );

endmodule

// *** verification/mode_reg_properties.sv ***
// Purpose: port checks of the working-mode register
// Assumes: sync active-low reset, one clock
// Notes:   shadow_reg mirrors the last mapped write
`timescale 1ns/10ps
module mode_reg_properties
  import mode_reg_pkg::*;
(
  input wire logic                    core_clk,
  input wire logic                    rst_n,
  input wire logic                    port_en,
  input wire logic                    port_we,
  input wire logic [4:0]              port_addr,
  input wire logic [15:0]             port_wdata,
  input wire logic [15:0]             port_rdata,
  input wire logic                    port_ready,
  input wire logic                    mode_written,
  input      mode_reg_pkg::seq_mode_e seq_mode,
  input wire logic                    event_driven,
  input wire logic                    high_rate,
  input wire logic                    clk_from_port,
  input wire logic [10:0]             max_rate_ksps,
  input wire logic                    chan_valid
);
  // ====================
  // shadow word and checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] shadow_reg;
  logic        wr_hit;
  logic        rd_any;
  assign wr_hit = port_en && port_we && port_addr == 5'h01;
  assign rd_any = port_en && !port_we;
  always_ff @(posedge core_clk)
    shadow_reg <= !rst_n ? 16'h0000 : wr_hit ? port_wdata : shadow_reg;
  ready_follow_a: assert property (port_en |=> port_ready)
    else $error("no ready after access");
  write_flag_a: assert property (wr_hit |=> mode_written && port_ready)
    else $error("write not flagged");
  read_back_a: assert property (rd_any && port_addr == 5'h01 |=> port_rdata == shadow_reg)
    else $error("read data differs");
  unmapped_zero_a: assert property (rd_any && port_addr != 5'h01 |=> port_rdata == 16'h0000)
    else $error("unmapped read not zero");
  seq_field_a: assert property (seq_mode == 4'b0001 << shadow_reg[15:14])
    else $error("sequence decode wrong");
  rate_sel_a: assert property (high_rate == shadow_reg[12] && max_rate_ksps == (high_rate ? 11'd1000 : 11'd500))
    else $error("rate decode wrong");
  trig_clk_a: assert property ({event_driven, clk_from_port} == {shadow_reg[13], shadow_reg[11]})
    else $error("trigger or clock decode wrong");
  chan_gate_a: assert property (chan_valid == (shadow_reg[5:2] < 4'hc && (&shadow_reg[15:14] || shadow_reg[12])))
    else $error("channel valid wrong");
  write_c: cover property (wr_hit);
  fast_chan_c: cover property (high_rate && chan_valid);
  unmapped_c: cover property (rd_any && port_addr != 5'h01);
endmodule
bind mode_reg_top mode_reg_properties chk (.core_clk, .rst_n, .port_en, .port_we, .port_addr, .port_wdata,
  .port_rdata, .port_ready, .mode_written, .seq_mode, .event_driven, .high_rate, .clk_from_port,
  .max_rate_ksps, .chan_valid);

// *** verification/port_host.sv ***
// Purpose: user logic that drives the reconfiguration port
// Assumes: caller enters access just after a rising edge
// Notes:   released data is inverted so stale values never pass
`timescale 1ns/10ps
module port_host
  import mode_reg_pkg::*;
(
  input  wire logic        core_clk,
  output logic             port_en,
  output logic             port_we,
  output logic [4:0]       port_addr,
  output logic [15:0]      port_wdata
);
  // ====================
  // one access per call
  initial begin
    port_en <= 1'b0;
    port_we <= 1'b0;
    port_addr <= 5'h00;
    port_wdata <= 16'h0000;
  end
  task automatic access(input logic we, input logic [4:0] a, input logic [15:0] d, input logic raw);
    port_en <= 1'b1;
    port_we <= we;
    port_addr <= a;
    port_wdata <= raw ? d : d & ~RESERVED_MASK;
    @(posedge core_clk);
    port_en <= 1'b0;
    port_addr <= ~a;
    port_wdata <= ~port_wdata;
  endtask
endmodule

// *** verification/tb_top.sv ***
// Purpose: self-checking bench of the working-mode register
// Assumes: ready one cycle after each access
// Notes:   expectations built from field positions only
`timescale 1ns/10ps
module tb_top
  import mode_reg_pkg::*;
;
  logic        core_clk, rst_n, port_en, port_we, port_ready, mode_written;
  logic        event_driven, high_rate, clk_from_port, chan_valid, reserved_nonzero;
  logic [4:0]  port_addr;
  logic [15:0] port_wdata, port_rdata;
  logic [10:0] max_rate_ksps;
  logic [11:0] input_sel, input_neg;
  seq_mode_e   seq_mode;
  supply_sel_e supply_sel;
  pairing_e    pairing;
  int          bad_count = 0;
  int          total_checks = 0;
  port_host host (.core_clk, .port_en, .port_we, .port_addr, .port_wdata);
  mode_reg_top #(.NUM_IN(12)) dut (.core_clk, .rst_n, .port_en, .port_we, .port_addr, .port_wdata,
    .port_rdata, .port_ready, .mode_written, .seq_mode, .event_driven, .high_rate, .clk_from_port,
    .max_rate_ksps, .supply_sel, .pairing, .input_sel, .input_neg, .chan_valid, .reserved_nonzero);
  // ====================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
    total_checks++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic xfer(input logic we, input logic [4:0] a, input logic [15:0] d, input logic raw);
    @(posedge core_clk);
    host.access(we, a, d, raw);
    #1;
    chk({port_ready, mode_written}, {1'b1, we && a == 5'h01}, "answer");
  endtask
  task automatic test_done;
    if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ====================
  // scenarios
  task automatic t_map;
    xfer(1'b0, 5'h01, 16'h0000, 1'b0);
    chk(port_rdata, 16'h0000, "reset word");
    xfer(1'b1, 5'h02, 16'hffff, 1'b0);
    xfer(1'b0, 5'h02, 16'h0000, 1'b0);
    chk(port_rdata, 16'h0000, "unmapped read");
    xfer(1'b0, 5'h01, 16'h0000, 1'b0);
    chk(port_rdata, 16'h0000, "unmapped write leak");
  endtask
  task automatic t_seq;
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, 5'h01, {s[1:0], 14'h0000}, 1'b0);
      chk(seq_mode, 16'h1 << s, "sequence");
      chk(max_rate_ksps, 16'd500, "rate");
    end
    xfer(1'b1, 5'h01, 16'h3800, 1'b0);
    chk({event_driven, high_rate, clk_from_port, max_rate_ksps}, 16'h3be8, "bits 13..11");
    xfer(1'b1, 5'h01, 16'h000c, 1'b0);
    chk({chan_valid, input_sel}, 16'h0000, "gated");
    xfer(1'b1, 5'h01, 16'h100c, 1'b0);
    chk({chan_valid, input_sel}, 16'h1008, "fast mode channel");
  endtask
  task automatic t_chan;
    logic [1:0]  p;
    logic [11:0] sel;
    logic [11:0] neg;
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, 5'h01, {8'hc0, m[1:0], 6'h00}, 1'b0);
      chk(supply_sel, m < 2 ? 16'h1 : 16'h1 << (m - 1), "supply");
    end
    for (int k = 0; k < 64; k++) begin
      p = k[5:4];
      sel = k[3:0] > 11 ? 12'h000 : p[0] ? 12'h003 << (k[3:0] & 4'he) : 12'h001 << k[3:0];
      neg = (k[3:0] < 12 && p == 2'b01) ? 12'h001 << (k[3:0] & 4'he) : 12'h000;
      xfer(1'b1, 5'h01, {8'hc0, 2'b00, k[3:0], p}, 1'b0);
      chk(pairing, !p[0] ? 16'h1 : p[1] ? 16'h4 : 16'h2, "pairing");
      chk(input_sel, sel, "inputs");
      chk({chan_valid, input_neg}, {k[3:0] < 12, neg}, "negative side");
    end
  endtask
  task automatic t_reserved;
    xfer(1'b1, 5'h01, 16'h0700, 1'b1);
    xfer(1'b0, 5'h01, 16'h0000, 1'b0);
    // flag and word checked apart: a 17-bit join would lose the flag in chk
    chk(port_rdata, 16'h0700, "raw reserved");
    chk(reserved_nonzero, 16'h0001, "reserved flag set");
    xfer(1'b1, 5'h01, 16'hffff, 1'b0);
    xfer(1'b0, 5'h01, 16'h0000, 1'b0);
    chk(port_rdata, 16'hf8ff, "masked write");
    chk(reserved_nonzero, 16'h0000, "reserved flag clear");
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    xfer(1'b0, 5'h01, 16'h0000, 1'b0);
    chk(port_rdata, 16'h0000, "after reset pulse");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    t_map;
    t_seq;
    t_chan;
    t_reserved;
    test_done;
  end
endmodule
